// >>> rtl/usmspi_pkg.sv
package usmspi_pkg;
  localparam int unsigned USMSPI_DATA_W = 8;
  localparam int unsigned USMSPI_DIV_W = 12;
  localparam int unsigned USMSPI_BIT_CNT_W = 4;
  localparam logic [3:0] USMSPI_FRAME_BITS = 4'h8;
  localparam logic [11:0] USMSPI_DIV_RST = 12'h000;
  localparam logic [7:0] USMSPI_BYTE_RST = 8'h00;
  localparam logic USMSPI_IDLE_OUT = 1'b1;

  typedef struct packed {
    logic txEnable;
    logic rxEnable;
    logic clockPolarity;
    logic clockPhase;
    logic bitOrder;
    logic [USMSPI_DIV_W-1:0] baudDivider;
  } usmspi_cfg_t;

  typedef struct packed {
    logic receiveCompleteFlag;
    logic transmitCompleteFlag;
    logic dataRegEmptyFlag;
    logic framingErrorFlag;
    logic overrunFlag;
    logic parityErrorFlag;
  } usmspi_stat_t;

  typedef struct packed {
    logic outDrive;
    logic outData;
    logic inTaken;
    logic clkDrive;
    logic clkLevel;
  } usmspi_pins_t;
endpackage : usmspi_pkg

// >>> rtl/usmspi_rxbuf.sv
`timescale 1ns/10ps
`default_nettype none
module usmspi_rxbuf
  import usmspi_pkg::*;
#(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 2
) (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  input wire logic flush,
  // fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // drain side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] rdPtr;
    logic [PW:0] count;
  } usmspi_rxbuf_st_t;

  usmspi_rxbuf_st_t st_ff;
  usmspi_rxbuf_st_t nxt_st;

  function automatic logic [PW-1:0] bumpPtr(input logic [PW-1:0] p);
    bumpPtr = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
  endfunction : bumpPtr

  logic pushIt;
  logic popIt;
  logic [PW-1:0] wrPtr;

  // full buffer refuses the newest word, older words survive
  assign inReady = (st_ff.count != (PW+1)'(DEPTH));
  assign outValid = (st_ff.count != '0);
  assign outData = st_ff.mem[st_ff.rdPtr];
  assign pushIt = inValid && inReady;
  assign popIt = outValid && outReady;
  assign wrPtr = PW'((st_ff.rdPtr + st_ff.count) % DEPTH);

  always_comb begin
    nxt_st = st_ff;
    if (pushIt) begin
      nxt_st.mem[wrPtr] = inData;
    end
    if (popIt) begin
      nxt_st.rdPtr = bumpPtr(st_ff.rdPtr);
    end
    nxt_st.count = (PW+1)'(st_ff.count + pushIt - popIt);
    if (flush) begin
      nxt_st.count = '0;
      nxt_st.rdPtr = '0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
endmodule : usmspi_rxbuf
`default_nettype wire

// >>> rtl/usmspi_master.sv
// Operation
// RULE1: software enables transmitter for any transfer; it makes the clock.
// RULE2: transmitter enabled drives serial out pin as master-out line.
// RULE3: receiver enabled takes serial in pin as master-in line.
// RULE4: transfer clock pin is the serial clock regardless of receiver.
// RULE5: writing the data register starts a transfer.
// RULE6: buffer byte enters shift register only when shifter is free.
// RULE7: software reads one byte per byte sent to keep alignment.
// RULE8: on receive overflow the newest byte is lost, older kept.
// RULE9: framing, overrun and parity flags always read zero.
// RULE10: receive, transmit complete, data empty flags act as usual.
// RULE11: clock polarity acts as standard SPI CPOL.
// RULE12: clock phase acts as standard SPI CPHA.
// RULE13: bit order picks LSB first or MSB first.
// RULE14: transmit path is double buffered.
// RULE15: receive path has one extra buffer level.
// RULE16: no write collision indication exists.
// RULE17: no double speed control; speed set by baud divider only.
// RULE18: master only; no slave select pin.
// RULE19: disabling transmitter or receiver acts as usual.
// RULE20: receive complete follows buffer occupancy; receiver off flushes it.
// RULE21: transmit complete sets when idle; cleared by ack or write one.
// RULE22: data empty shows buffer free, set after reset.
// RULE23: transmitter disable waits until frame and buffer are sent.
// RULE24: input sampled each frame, byte stored at end if receiver on.
`timescale 1ns/10ps
`default_nettype none
module usmspi_master
  import usmspi_pkg::*;
#(
  parameter int unsigned DATA_W = USMSPI_DATA_W,
  parameter int unsigned RX_DEPTH = 2
) (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // configuration
  input wire usmspi_cfg_t cfg,
  // data register access
  input wire logic dataWrite,
  input wire logic [DATA_W-1:0] dataWrData,
  input wire logic dataRead,
  output logic [DATA_W-1:0] dataRdData,
  // flag clearing
  input wire logic txCompleteClear,
  input wire logic txCompleteAck,
  // status
  output usmspi_stat_t status,
  output logic txActive,
  // pins
  input wire logic serialInPin,
  output usmspi_pins_t pins
);
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_LEAD,
    ST_TRAIL
  } usmspi_phase_t;

  typedef struct packed {
    usmspi_phase_t phase;
    logic [DATA_W-1:0] txBuf;
    logic txBufFull;
    logic [DATA_W-1:0] shiftOut;
    logic [DATA_W-1:0] shiftIn;
    logic [USMSPI_BIT_CNT_W-1:0] bitCnt;
    logic [USMSPI_DIV_W-1:0] divCnt;
    logic sclk;
    logic mosi;
    logic txOn;
    logic txDone;
    logic rxPush;
    logic [DATA_W-1:0] rxWord;
    logic [DATA_W-1:0] rdData;
  } usmspi_st_t;

  usmspi_st_t st_ff;
  usmspi_st_t nxt_st;

  logic rxReady;
  logic rxValid;
  logic [DATA_W-1:0] rxHead;

  // next bit to present on the data line, per bit order
  function automatic logic pickBit(input logic [DATA_W-1:0] d,
                                   input logic lsbFirst);
    pickBit = lsbFirst ? d[0] : d[DATA_W-1]; // see RULE13
  endfunction : pickBit

  function automatic logic [DATA_W-1:0] shiftOn(input logic [DATA_W-1:0] d,
                                                input logic lsbFirst,
                                                input logic b);
    shiftOn = lsbFirst ? {b, d[DATA_W-1:1]} : {d[DATA_W-2:0], b};
  endfunction : shiftOn

  logic tick;
  logic lastBit;
  assign tick = (st_ff.divCnt == '0); // see RULE17
  assign lastBit = (st_ff.bitCnt == USMSPI_FRAME_BITS - 4'h1);

  always_comb begin
    nxt_st = st_ff;
    nxt_st.rxPush = 1'b0;
    // disable waits for shifter and buffer to drain
    if (cfg.txEnable) begin
      nxt_st.txOn = 1'b1;
    end else if (st_ff.phase == ST_IDLE && !st_ff.txBufFull) begin
      nxt_st.txOn = 1'b0; // see RULE23
    end
    // second byte may queue while a frame shifts
    if (dataWrite && !st_ff.txBufFull && st_ff.txOn) begin
      nxt_st.txBuf = dataWrData; // see RULE5
      nxt_st.txBufFull = 1'b1; // see RULE14
    end
    nxt_st.divCnt = tick ? cfg.baudDivider
                         : USMSPI_DIV_W'(st_ff.divCnt - 1'b1);
    if (!st_ff.txOn) begin
      nxt_st.sclk = cfg.clockPolarity;
    end
    case (st_ff.phase)
      ST_IDLE: begin
        nxt_st.sclk = cfg.clockPolarity; // see RULE11
        if (st_ff.txBufFull && st_ff.txOn) begin
          nxt_st.shiftOut = st_ff.txBuf; // see RULE6
          nxt_st.txBufFull = 1'b0;
          nxt_st.bitCnt = '0;
          nxt_st.divCnt = cfg.baudDivider;
          nxt_st.phase = ST_LEAD;
          // phase 0 sets data before the first edge
          nxt_st.mosi = pickBit(st_ff.txBuf, cfg.bitOrder); // see RULE12
        end
      end
      ST_LEAD: begin
        if (tick) begin
          nxt_st.sclk = ~st_ff.sclk;
          nxt_st.phase = ST_TRAIL;
          if (!cfg.clockPhase) begin
            nxt_st.shiftIn = shiftOn(st_ff.shiftIn, cfg.bitOrder,
                                     serialInPin); // see RULE24
          end else begin
            nxt_st.mosi = pickBit(st_ff.shiftOut, cfg.bitOrder);
          end
        end
      end
      ST_TRAIL: begin
        if (tick) begin
          nxt_st.sclk = ~st_ff.sclk;
          if (cfg.clockPhase) begin
            nxt_st.shiftIn = shiftOn(st_ff.shiftIn, cfg.bitOrder,
                                     serialInPin); // see RULE24
          end
          nxt_st.shiftOut = shiftOn(st_ff.shiftOut, cfg.bitOrder, 1'b0);
          if (lastBit) begin
            nxt_st.phase = ST_IDLE;
            nxt_st.rxPush = cfg.rxEnable; // see RULE24
            nxt_st.rxWord = cfg.clockPhase
              ? shiftOn(st_ff.shiftIn, cfg.bitOrder, serialInPin)
              : st_ff.shiftIn;
            nxt_st.txDone = 1'b1;
          end else begin
            nxt_st.bitCnt = USMSPI_BIT_CNT_W'(st_ff.bitCnt + 1'b1);
            nxt_st.phase = ST_LEAD;
            if (!cfg.clockPhase) begin
              nxt_st.mosi = pickBit(
                shiftOn(st_ff.shiftOut, cfg.bitOrder, 1'b0), cfg.bitOrder);
            end
          end
        end
      end
      default: begin
        nxt_st.phase = ST_IDLE;
      end
    endcase
    // complete only when no queued byte follows; set beats clear
    if (txCompleteClear || txCompleteAck) begin
      nxt_st.txDone = 1'b0; // see RULE21
    end
    if (st_ff.phase == ST_TRAIL && tick && lastBit) begin
      nxt_st.txDone = !st_ff.txBufFull && !(dataWrite && st_ff.txOn);
    end
    if (dataWrite && st_ff.txOn) begin
      nxt_st.txDone = 1'b0;
    end
    if (dataRead) begin
      nxt_st.rdData = rxHead;
    end
    if (!st_ff.txOn && !cfg.txEnable) begin
      nxt_st.mosi = USMSPI_IDLE_OUT; // see RULE19
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      st_ff <= '{phase: ST_IDLE, txBuf: USMSPI_BYTE_RST, txBufFull: 1'b0,
                 shiftOut: USMSPI_BYTE_RST, shiftIn: USMSPI_BYTE_RST,
                 bitCnt: '0, divCnt: USMSPI_DIV_RST, sclk: 1'b0,
                 mosi: USMSPI_IDLE_OUT, txOn: 1'b0, txDone: 1'b0,
                 rxPush: 1'b0, rxWord: USMSPI_BYTE_RST,
                 rdData: USMSPI_BYTE_RST};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // extra receive level; full buffer drops the newest byte
  usmspi_rxbuf #(
    .WIDTH(DATA_W),
    .DEPTH(RX_DEPTH)
  ) u_rxbuf (
    .mclk(mclk),
    .nrst(nrst),
    .flush(!cfg.rxEnable), // see RULE20
    .inValid(st_ff.rxPush), // see RULE8
    .inReady(rxReady),
    .inData(st_ff.rxWord),
    .outValid(rxValid),
    .outReady(dataRead), // see RULE15
    .outData(rxHead)
  );

  assign dataRdData = st_ff.rdData;
  assign txActive = st_ff.txOn;

  // receive complete and data empty flags mirror buffer state directly
  always_comb begin
    status.receiveCompleteFlag = rxValid; // see RULE20
    status.transmitCompleteFlag = st_ff.txDone; // see RULE10
    status.dataRegEmptyFlag = !st_ff.txBufFull; // see RULE22
    status.framingErrorFlag = 1'b0; // see RULE9
    status.overrunFlag = 1'b0; // see RULE9
    status.parityErrorFlag = 1'b0; // see RULE9
  end

  // no slave select and no collision flag exist at all; see RULE16
  always_comb begin
    pins.outDrive = st_ff.txOn; // see RULE2
    pins.outData = st_ff.mosi;
    pins.inTaken = cfg.rxEnable; // see RULE3
    pins.clkDrive = st_ff.txOn; // see RULE4
    pins.clkLevel = st_ff.sclk; // see RULE18
  end
endmodule : usmspi_master
`default_nettype wire

// >>> tb/usmspi_slave_model.sv
`timescale 1ns/10ps
`default_nettype none
module usmspi_slave_model
  import usmspi_pkg::*;
#(
  parameter logic [7:0] INIT = 8'h5A
) (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // lines from the master
  input wire usmspi_cfg_t cfg,
  input wire usmspi_pins_t pins,
  // reply and capture
  output logic miso,
  output logic [7:0] lastRx
);
  logic prevClk, armed, lead, trail, smp, bitv;
  logic [2:0] cnt;
  logic [7:0] sh, nxtSh;
  // only the clock line is seen; no select exists
  assign lead = pins.clkLevel != prevClk && prevClk == cfg.clockPolarity;
  // idle level moves land on the new polarity, so they never count
  assign trail = pins.clkLevel != prevClk && armed;
  assign smp = cfg.clockPhase ? trail : lead;
  assign bitv = lastRx[cfg.bitOrder ? cnt : 3'h7 - cnt];
  assign nxtSh = cfg.bitOrder ? {pins.outData, sh[7:1]}
                              : {sh[6:0], pins.outData};
  // a released line shows the inverse, never a stale match
  assign miso = pins.clkDrive ? bitv : ~bitv;
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      prevClk <= 1'b0;
      armed <= 1'b0;
      cnt <= 3'h0;
      sh <= 8'h00;
      lastRx <= INIT;
    end else begin
      prevClk <= pins.clkLevel;
      armed <= lead ? 1'b1 : (trail ? 1'b0 : armed);
      if (smp) begin
        sh <= nxtSh;
        cnt <= cnt + 3'h1;
        lastRx <= (cnt == 3'h7) ? nxtSh : lastRx;
      end
    end
  end
endmodule : usmspi_slave_model
`default_nettype wire

// >>> tb/usmspi_checker.sv
`timescale 1ns/10ps
`default_nettype none
module usmspi_checker
  import usmspi_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // inputs
  input wire usmspi_cfg_t cfg,
  input wire logic dataWrite,
  input wire logic txCompleteClear,
  input wire logic txCompleteAck,
  // outputs
  input wire usmspi_stat_t status,
  input wire logic txActive,
  input wire usmspi_pins_t pins
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);
  sequence s_take;
    dataWrite && status.dataRegEmptyFlag;
  endsequence
  // settings must hold over both cycles: the idle clock follows them late
  sequence s_idle;
    status.transmitCompleteFlag && $stable(cfg)
      ##1 status.transmitCompleteFlag && $stable(cfg);
  endsequence
  err_zero_a: assert property (
    !(status.framingErrorFlag || status.overrunFlag || status.parityErrorFlag))
    else $error("error flag set");
  tx_pins_a: assert property (
    pins.outDrive == txActive && pins.clkDrive == txActive)
    else $error("drive");
  rx_pin_a: assert property (
    pins.inTaken == cfg.rxEnable) else $error("input pin taken");
  out_idle_a: assert property (
    !txActive && $past(!txActive) |-> pins.outData) else $error("out idle");
  rx_flush_a: assert property (
    !cfg.rxEnable ##1 !cfg.rxEnable |-> !status.receiveCompleteFlag)
    else $error("rx not flushed");
  buf_full_a: assert property (
    s_take and txActive |=> !status.dataRegEmptyFlag) else $error("write lost");
  tx_refuse_a: assert property (
    s_take and !txActive |=> status.dataRegEmptyFlag) else $error("refused");
  txc_clear_a: assert property (
    status.transmitCompleteFlag && !dataWrite
    && (txCompleteClear || txCompleteAck)
    |=> !status.transmitCompleteFlag) else $error("tx complete kept");
  clk_still_a: assert property (
    s_idle |-> $stable(pins.clkLevel)) else $error("clock moved idle");
endmodule : usmspi_checker
bind usmspi_master usmspi_checker i_chk (.mclk, .nrst, .cfg, .dataWrite,
  .txCompleteClear, .txCompleteAck, .status, .txActive, .pins);
`default_nettype wire

// >>> tb/test_usart_spi_master_transfer.sv
`timescale 1ns/10ps
`default_nettype none
module test_usart_spi_master_transfer
  import usmspi_pkg::*;
;
  logic mclk, nrst, dataWrite, dataRead, txCompleteClear, txCompleteAck;
  logic serialInPin, txActive;
  logic [7:0] dataWrData, dataRdData, lastRx, prev;
  usmspi_cfg_t cfg;
  usmspi_stat_t status;
  usmspi_pins_t pins;
  int errors, n_tests, i;
  // polarity, phase, lsb first, byte; echo reply is the previous byte
  logic [10:0] rows [8] = '{11'h0A5, 11'h13C, 11'h2C3, 11'h381,
    11'h47E, 11'h501, 11'h6FF, 11'h700};
  usmspi_master i_dut (.mclk, .nrst, .cfg, .dataWrite, .dataWrData,
    .dataRead, .dataRdData, .txCompleteClear, .txCompleteAck, .status,
    .txActive, .serialInPin, .pins);
  usmspi_slave_model i_slave (.mclk, .nrst, .cfg, .pins,
    .miso(serialInPin), .lastRx);
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic results();
    $display("checks %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : results
  task automatic send(input logic [7:0] b);
    for (int k = 0; k < 400 && status.dataRegEmptyFlag !== 1'b1; k++) begin
      @(negedge mclk);
    end
    check(status.dataRegEmptyFlag, 1'b1);
    dataWrite = 1'b1;
    dataWrData = b;
    @(negedge mclk);
    dataWrite = 1'b0;
  endtask : send
  task automatic wait_flag(input bit rx);
    logic flag;
    for (int k = 0; k < 400; k++) begin
      flag = rx ? status.receiveCompleteFlag : status.transmitCompleteFlag;
      if (flag === 1'b1) break;
      @(negedge mclk);
    end
    // a wait that runs out counts as a mismatch
    flag = rx ? status.receiveCompleteFlag : status.transmitCompleteFlag;
    check(flag, 1'b1);
  endtask : wait_flag
  // data stands until the next read, so one spare cycle is harmless
  task automatic rd();
    dataRead = 1'b1;
    @(negedge mclk);
    dataRead = 1'b0;
    @(negedge mclk);
  endtask : rd
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  // frames take about 50 cycles; this leaves a wide margin
  initial begin
    repeat (30000) @(posedge mclk);
    errors++;
    results();
  end
  initial begin
    {nrst, dataWrite, dataRead, txCompleteClear, txCompleteAck} = 5'h00;
    dataWrData = 8'h00;
    cfg = '0;
    repeat (6) @(negedge mclk);
    nrst = 1'b1;
    @(negedge mclk);
    check(status.dataRegEmptyFlag, 1'b1);
    check(status.transmitCompleteFlag, 1'b0);
    check(pins.outData, USMSPI_IDLE_OUT);
    send(8'h3C);
    repeat (100) @(negedge mclk);
    check(lastRx, 8'h5A);
    cfg.txEnable = 1'b1;
    cfg.rxEnable = 1'b1;
    cfg.baudDivider = 12'h002;
    prev = 8'h5A;
    for (i = 0; i < 8; i++) begin
      {cfg.clockPolarity, cfg.clockPhase, cfg.bitOrder} = rows[i][10:8];
      @(negedge mclk);
      send(rows[i][7:0]);
      wait_flag(1'b1);
      check(lastRx, rows[i][7:0]);
      check(pins.clkLevel, rows[i][10]);
      check(status.transmitCompleteFlag, 1'b1);
      rd();
      check(dataRdData, prev);
      prev = rows[i][7:0];
      {txCompleteAck, txCompleteClear} = i[0] ? 2'b10 : 2'b01;
      @(negedge mclk);
      {txCompleteAck, txCompleteClear} = 2'b00;
      check(status.transmitCompleteFlag, 1'b0);
    end
    send(8'h11);
    send(8'h22);
    check(status.dataRegEmptyFlag, 1'b0);
    send(8'h33);
    wait_flag(1'b0);
    @(negedge mclk);
    check(lastRx, 8'h33);
    rd();
    check(dataRdData, prev);
    rd();
    check(dataRdData, 8'h11);
    check(status.receiveCompleteFlag, 1'b0);
    send(8'h44);
    cfg.txEnable = 1'b0;
    wait_flag(1'b0);
    // slave takes the last bit one cycle after the final clock edge
    @(negedge mclk);
    check(lastRx, 8'h44);
    repeat (3) @(negedge mclk);
    check(pins.outDrive, 1'b0);
    cfg.rxEnable = 1'b0;
    repeat (2) @(negedge mclk);
    check(status.receiveCompleteFlag, 1'b0);
    check(pins.inTaken, 1'b0);
    results();
  end
endmodule : test_usart_spi_master_transfer
`default_nettype wire
